// ==== verilog/cmap_core.sv ====
// Customer data region, private key and factory default store
`timescale 1ns/1ps
module cmap_core
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pin_try,
  input wire logic [cmap_pkg::PIN_W-1:0] pin_val,
  input wire logic lock_req,
  input wire logic page_rd,
  input wire logic page_wr,
  input wire logic [cmap_pkg::ADDR_W-1:0] page_idx,
  input wire logic [31:0] page_wdata,
  input wire logic key_wr,
  input wire logic [cmap_pkg::KEY_W-1:0] key_wdata,
  input wire logic pin_wr,
  input wire logic [cmap_pkg::PIN_W-1:0] pin_wdata,
  input wire logic factory_reset,
  output logic protected_mode,
  output logic page_ack,
  output logic page_err,
  output logic [31:0] page_rdata,
  output logic [cmap_pkg::KEY_W-1:0] sec_key,
  output logic [cmap_pkg::SRC_W-1:0] src_addr,
  output logic [cmap_pkg::MFR_W-1:0] mfr_id,
  output logic restore_busy
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    cmap_pkg::cmap_state_t st;
    logic prot;
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic [cmap_pkg::KEY_W-1:0] key;
    logic [cmap_pkg::SRC_W-1:0] src;
    logic [cmap_pkg::MFR_W-1:0] mfr;
    logic [cmap_pkg::PIN_W-1:0] pin;
  } cmap_regs_t;

  cmap_regs_t s_r;
  cmap_regs_t s_nxt;
  logic [31:0] mem [0:cmap_pkg::PAGE_COUNT-1];
  logic in_range;
  logic wr_ok;

  function automatic logic cmap_in_region(input logic [cmap_pkg::ADDR_W-1:0] idx);
    cmap_in_region = (idx <= cmap_pkg::LAST_PAGE);
  endfunction

  assign in_range = cmap_in_region(page_idx);
  assign wr_ok = ce && page_wr && s_r.prot && in_range && !factory_reset
    && (s_r.st == cmap_pkg::CMAP_IDLE);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    case (s_r.st)
      cmap_pkg::CMAP_IDLE:
      begin
        if (factory_reset)
        begin
          s_nxt.st = cmap_pkg::CMAP_RESTORE;
          s_nxt.prot = 1'b0;
        end
        else
        begin
          if (lock_req)
            s_nxt.prot = 1'b0;
          else if (pin_try)
            s_nxt.prot = (pin_val == s_r.pin);
          if (page_rd || page_wr)
          begin
            s_nxt.ack = 1'b1;
            s_nxt.err = !(s_r.prot && in_range);
            if (page_rd && s_r.prot && in_range)
              s_nxt.rdata = mem[page_idx[cmap_pkg::PAGE_AW-1:0]];
          end
          if (key_wr)
            s_nxt.key = key_wdata;
          if (pin_wr && s_r.prot)
            s_nxt.pin = pin_wdata;
        end
      end
      cmap_pkg::CMAP_RESTORE:
      begin
        // Backup copied into active settings; customer pages untouched
        s_nxt.key = cmap_pkg::DEF_KEY;
        s_nxt.src = cmap_pkg::DEF_SRC;
        s_nxt.mfr = cmap_pkg::DEF_MFR;
        s_nxt.pin = cmap_pkg::DEF_PIN;
        s_nxt.st = cmap_pkg::CMAP_IDLE;
      end
      default:
        s_nxt.st = cmap_pkg::CMAP_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r.st <= cmap_pkg::CMAP_IDLE;
      s_r.prot <= 1'b0;
      s_r.ack <= 1'b0;
      s_r.err <= 1'b0;
      s_r.rdata <= 32'h00000000;
      s_r.key <= cmap_pkg::DEF_KEY;
      s_r.src <= cmap_pkg::DEF_SRC;
      s_r.mfr <= cmap_pkg::DEF_MFR;
      s_r.pin <= cmap_pkg::DEF_PIN;
    end
    else if (ce)
      s_r <= s_nxt;
  end

  // ------------------------------------------------------------
  // Customer page store, written only by the reader
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (wr_ok)
      mem[page_idx[cmap_pkg::PAGE_AW-1:0]] <= page_wdata;
  end

  // ------------------------------------------------------------
  // Outputs; backup and PIN have no read path
  // ------------------------------------------------------------
  assign protected_mode = s_r.prot;
  assign page_ack = s_r.ack;
  assign page_err = s_r.err;
  assign page_rdata = s_r.rdata;
  assign sec_key = s_r.key;
  assign src_addr = s_r.src;
  assign mfr_id = s_r.mfr;
  assign restore_busy = (s_r.st == cmap_pkg::CMAP_RESTORE);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence seq_reset_req;
    ce && !restore_busy && factory_reset;
  endsequence
  sequence seq_defaults;
    sec_key == cmap_pkg::DEF_KEY && src_addr == cmap_pkg::DEF_SRC && mfr_id == cmap_pkg::DEF_MFR;
  endsequence

  AST_OUT_OF_RANGE: assert property (@(posedge clk) disable iff (rst)
    ce && !restore_busy && !factory_reset && page_rd && !in_range |=> page_ack && page_err)
    else $error("Access beyond region not refused");
  AST_UNPROT_REFUSED: assert property (@(posedge clk) disable iff (rst)
    ce && !restore_busy && !factory_reset && (page_rd || page_wr) && !protected_mode
      |=> page_err)
    else $error("Unprotected access accepted");
  AST_NO_INT_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_ok |-> page_wr && protected_mode ##1 page_ack && !page_err)
    else $error("Page written without reader request");
  AST_RESTORE_DEFAULTS: assert property (@(posedge clk) disable iff (rst)
    seq_reset_req ##1 ce |=> seq_defaults)
    else $error("Defaults not restored");
  AST_RESET_LOCKS: assert property (@(posedge clk) disable iff (rst)
    seq_reset_req |=> !protected_mode && restore_busy)
    else $error("Factory reset did not lock");
  AST_DEF_PIN_UNLOCK: assert property (@(posedge clk) disable iff (rst)
    ce && !restore_busy && !factory_reset && !lock_req && pin_try && pin_val == cmap_pkg::DEF_PIN
      && ($past(restore_busy) || $past(restore_busy, 2))
      |=> protected_mode)
    else $error("Default PIN did not unlock");
  AST_NO_PRIV_READ: assert property (@(posedge clk) disable iff (rst)
    page_ack && page_err |-> page_rdata == $past(page_rdata))
    else $error("Refused read changed data");
  AST_KEY_STABLE: assert property (@(posedge clk) disable iff (rst)
    !key_wr && !restore_busy |=> $stable(sec_key))
    else $error("Key changed without key write");

  AST_RESTORE_ONE: assert property (@(posedge clk) disable iff (rst)
    ce && restore_busy |=> !restore_busy)
    else $error("Restore did not finish in one cycle");
  AST_KEY_WRITE: assert property (@(posedge clk) disable iff (rst)
    ce && !restore_busy && !factory_reset && key_wr |=> sec_key == $past(key_wdata))
    else $error("Key write did not land");
  AST_SRC_STABLE: assert property (@(posedge clk) disable iff (rst)
    !restore_busy |=> $stable(src_addr) && $stable(mfr_id))
    else $error("Address or maker code changed outside restore");
  AST_ACCESS_OK: assert property (@(posedge clk) disable iff (rst)
    ce && !restore_busy && !factory_reset && (page_rd || page_wr) && protected_mode && in_range
      |=> page_ack && !page_err)
    else $error("Protected access refused");
  AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(protected_mode) && $stable(page_ack) && $stable(page_rdata))
    else $error("State moved while enable low");
  AST_LOCK_CLEARS: assert property (@(posedge clk) disable iff (rst)
    ce && !restore_busy && !factory_reset && lock_req |=> !protected_mode)
    else $error("Lock request ignored");
  AST_NO_REQ_NO_ACK: assert property (@(posedge clk) disable iff (rst)
    ce && (restore_busy || factory_reset || !(page_rd || page_wr)) |=> !page_ack)
    else $error("Answer without a taken request");
  AST_PIN_LOCKED: assert property (@(posedge clk) disable iff (rst)
    ce && !restore_busy && !factory_reset && pin_wr && !protected_mode |=> $stable(s_r.pin))
    else $error("PIN written outside protected mode");
endmodule // cmap_core

// ==== verilog/cmap_pkg.sv ====
// Constants for the configuration memory access policy block
package cmap_pkg;
  localparam int unsigned PAGE_COUNT = 64;
  localparam int unsigned PAGE_BYTES = 4;
  localparam int unsigned REGION_BYTES = 256;
  localparam int unsigned PAGE_AW = 6;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned KEY_W = 128;
  localparam int unsigned SRC_W = 48;
  localparam int unsigned MFR_W = 16;
  localparam int unsigned PIN_W = 32;
  localparam logic [ADDR_W-1:0] LAST_PAGE = 8'h3f;
  // Arbitrary neutral factory values
  localparam logic [SRC_W-1:0] DEF_SRC = 48'h000000000001;
  localparam logic [KEY_W-1:0] DEF_KEY = 128'h00112233445566778899aabbccddeeff;
  localparam logic [MFR_W-1:0] DEF_MFR = 16'h0001;
  localparam logic [PIN_W-1:0] DEF_PIN = 32'h00001234;
  typedef enum logic [1:0] {
    CMAP_IDLE = 2'b00,
    CMAP_RESTORE = 2'b01
  } cmap_state_t;
endpackage

// ==== sim/cmap_reader.sv ====
// Reader model for the configuration interface
`timescale 1ns/1ps
module cmap_reader
(
  input wire logic clk,
  output logic pin_try,
  output logic [31:0] pin_val,
  output logic lock_req,
  output logic page_rd,
  output logic page_wr,
  output logic [7:0] page_idx,
  output logic [31:0] page_wdata
);
  initial {pin_try, pin_val, lock_req, page_rd, page_wr, page_idx, page_wdata} = '0;
  // One request pulse: 0 pin, 1 write, 2 read, 3 lock
  task automatic op(input logic [1:0] k, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk);
    #1 pin_try = (k == 2'h0);
    pin_val = d;
    page_wr = (k == 2'h1);
    page_rd = (k == 2'h2);
    lock_req = (k == 2'h3);
    page_idx = i;
    page_wdata = d;
    @(posedge clk);
    #1 {pin_try, lock_req, page_rd, page_wr} = '0;
    pin_val = ~d;
    page_wdata = ~d;
  endtask
endmodule // cmap_reader

// ==== sim/test_cmap_core.sv ====
// Self-checking bench for the configuration memory access block
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %h / %h", $time, a, b); end end
module test_cmap_core;
  logic clk = 0, rst = 1, ce = 1, key_wr = 0, pin_wr = 0, factory_reset = 0;
  logic [127:0] key_wdata = '0, sec_key;
  logic [31:0] pin_wdata = '0, pin_val, page_wdata, page_rdata;
  logic pin_try, lock_req, page_rd, page_wr, protected_mode, page_ack, page_err, restore_busy;
  logic [7:0] page_idx;
  logic [47:0] src_addr;
  logic [15:0] mfr_id;
  int fails = 0, checks_done = 0;
  logic [76:0] rows [11];
  always #2.5 clk = ~clk;
  cmap_reader rd_u (.clk(clk), .pin_try(pin_try), .pin_val(pin_val), .lock_req(lock_req),
    .page_rd(page_rd), .page_wr(page_wr), .page_idx(page_idx), .page_wdata(page_wdata));
  cmap_core dut_u (.clk(clk), .rst(rst), .ce(ce), .pin_try(pin_try), .pin_val(pin_val),
    .lock_req(lock_req), .page_rd(page_rd), .page_wr(page_wr), .page_idx(page_idx),
    .page_wdata(page_wdata), .key_wr(key_wr), .key_wdata(key_wdata), .pin_wr(pin_wr),
    .pin_wdata(pin_wdata), .factory_reset(factory_reset), .protected_mode(protected_mode),
    .page_ack(page_ack), .page_err(page_err), .page_rdata(page_rdata), .sec_key(sec_key),
    .src_addr(src_addr), .mfr_id(mfr_id), .restore_busy(restore_busy));
  task automatic hit(ref logic s);
    @(posedge clk);
    #1 s = 1;
    @(posedge clk);
    #1 s = 0;
  endtask
  task automatic close_out;
    $display("checks %0d, wrong %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #5000 fails++;
    close_out;
  end
  initial
  begin
    // Rows: op, page, data, expected ack/err/protected, expected read data
    rows = '{{2'h1, 8'h05, 32'h11223344, 3'b110, 32'h0},
      {2'h0, 8'h00, cmap_pkg::DEF_PIN, 3'b001, 32'h0},
      {2'h1, 8'h05, 32'ha5a5a5a5, 3'b101, 32'h0},
      {2'h1, 8'h3f, 32'h5a5a5a5a, 3'b101, 32'h0},
      {2'h1, 8'h45, 32'hdeadbeef, 3'b111, 32'h0},
      {2'h2, 8'h05, 32'h0, 3'b101, 32'ha5a5a5a5},
      {2'h2, 8'h40, 32'h0, 3'b111, 32'ha5a5a5a5},
      {2'h2, 8'h3f, 32'h0, 3'b101, 32'h5a5a5a5a},
      {2'h0, 8'h00, 32'hffffffff, 3'b000, 32'h5a5a5a5a},
      {2'h3, 8'h00, 32'h0, 3'b000, 32'h5a5a5a5a},
      {2'h2, 8'h05, 32'h0, 3'b110, 32'h5a5a5a5a}};
    repeat (20) @(posedge clk);
    #1 rst = 0;
    `CHK(sec_key, cmap_pkg::DEF_KEY)
    foreach (rows[n])
    begin
      rd_u.op(rows[n][76:75], rows[n][74:67], rows[n][66:35]);
      `CHK({page_ack, page_err, protected_mode}, rows[n][34:32])
      `CHK(page_rdata, rows[n][31:0])
    end
    $display("test rows done");
    key_wdata = ~cmap_pkg::DEF_KEY;
    hit(key_wr);
    `CHK(sec_key, ~cmap_pkg::DEF_KEY)
    pin_wdata = 32'h0000beef;
    hit(pin_wr);
    rd_u.op(2'h0, 8'h00, cmap_pkg::DEF_PIN);
    `CHK(protected_mode, 1'b1)
    hit(pin_wr);
    rd_u.op(2'h0, 8'h00, cmap_pkg::DEF_PIN);
    `CHK(protected_mode, 1'b0)
    hit(factory_reset);
    `CHK({restore_busy, protected_mode}, 2'b10)
    @(posedge clk);
    #1 `CHK({sec_key, src_addr, mfr_id}, {cmap_pkg::DEF_KEY, cmap_pkg::DEF_SRC, cmap_pkg::DEF_MFR})
    rd_u.op(2'h0, 8'h00, cmap_pkg::DEF_PIN);
    `CHK(protected_mode, 1'b1)
    rd_u.op(2'h2, 8'h05, 32'h0);
    `CHK(page_rdata, 32'ha5a5a5a5)
    rd_u.op(2'h2, 8'hff, 32'h0);
    `CHK({page_err, page_rdata}, {1'b1, 32'ha5a5a5a5})
    $display("test restore done");
    @(posedge clk);
    #1 ce = 0;
    rd_u.op(2'h1, 8'h3f, 32'h0f0f0f0f);
    `CHK({page_ack, page_err}, 2'b00)
    ce = 1;
    rd_u.op(2'h2, 8'h3f, 32'h0);
    `CHK(page_rdata, 32'h5a5a5a5a)
    fork
      rd_u.op(2'h1, 8'h05, 32'h0f0f0f0f);
      hit(factory_reset);
    join
    `CHK({page_ack, restore_busy}, 2'b01)
    rd_u.op(2'h0, 8'h00, cmap_pkg::DEF_PIN);
    rd_u.op(2'h2, 8'h05, 32'h0);
    `CHK(page_rdata, 32'ha5a5a5a5)
    $display("test awkward done");
    hit(key_wr);
    hit(rst);
    `CHK({sec_key, protected_mode}, {cmap_pkg::DEF_KEY, 1'b0})
    $display("test reset done");
    close_out;
  end
endmodule // test_cmap_core
